// File: verilog/ckg_top.sv
// clock generator: mode control, loop, reference and bus dividers
// assumes: one 200 MHz clock; clocks leave as one-cycle enable pulses;
// external reference arrives as a synchronous one-cycle tick
`include "ckg_map.svh"
module ckg_top
  import ckg_pkg::*;
#(
  parameter int IRC_CYCLES = `CKG_IRC_CYCLES,
  parameter int FLL_CW     = 16,
  parameter int MULT_LOG2  = 2
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic      [7:0] rdata_o,
  input  wire logic       ext_ref_tick_i,
  input  wire logic       stop_i,
  output logic            generator_output_clock_o,
  output logic            background_debug_clock_o,
  output logic            fixed_frequency_clock_o,
  output logic            fixed_frequency_valid_o,
  output logic            ext_ref_running_o
);

  localparam int IRC_W = $clog2(IRC_CYCLES + 1);

  ckg_mode_t    mode_q;
  ckg_mode_t    mode_d;
  ckg_mode_t    eff_mode;
  logic [2:0]   reference_divider_q;
  logic [2:0]   reference_divider_d;
  logic [1:0]   bus_clock_divider_q;
  logic [1:0]   bus_clock_divider_d;
  logic         ext_ref_clock_enable_q;
  logic         ext_ref_stop_enable_q;
  logic         ffe_q;
  logic [IRC_W-1:0] irc_cnt_q;
  logic         irc_tick_q;
  logic         ext_run;
  logic         ext_tick;
  logic         src_tick;
  logic         dbg_clk_q;
  logic [7:0]   stat;

  ckg_fll_if fll_if ();

  // stop overrides the programmed mode; the mode register keeps its value
  assign eff_mode = stop_i ? CLOCK_STOP : mode_q;

  // next register values; stop and the unused code are not writable
  always_comb begin
    mode_d              = mode_q;
    reference_divider_d = reference_divider_q;
    bus_clock_divider_d = bus_clock_divider_q;
    if (we_i && addr_i == `CKG_CTRL_OFS &&
        ckg_run_mode(wdata_i[`CKG_CTRL_MODE_LSB +: 3]))
      mode_d = ckg_mode_t'(wdata_i[`CKG_CTRL_MODE_LSB +: 3]);
    if (we_i && addr_i == `CKG_DIV_OFS) begin
      reference_divider_d = wdata_i[`CKG_DIV_REF_LSB +: 3];
      bus_clock_divider_d = wdata_i[`CKG_DIV_BUS_LSB +: 2];
    end
  end

  // mode register, engaged internal out of reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      mode_q <= ckg_mode_t'(`CKG_RST_MODE);
    else
      mode_q <= mode_d;
  end

  // divider fields
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reference_divider_q <= `CKG_RST_REF_DIV;
      bus_clock_divider_q <= `CKG_RST_BUS_DIV;
    end else begin
      reference_divider_q <= reference_divider_d;
      bus_clock_divider_q <= bus_clock_divider_d;
    end
  end

  // external reference enables
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_ref_clock_enable_q <= 1'b0;
      ext_ref_stop_enable_q  <= 1'b0;
    end else if (we_i && addr_i == `CKG_CTRL_OFS) begin
      ext_ref_clock_enable_q <= wdata_i[`CKG_CTRL_EXT_CLK_EN];
      ext_ref_stop_enable_q  <= wdata_i[`CKG_CTRL_EXT_STOP_EN];
    end
  end

  // valid flag from the next field values, so it never lags a write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      ffe_q <= 1'b1;
    else
      ffe_q <= ckg_ffe_ok(mode_d, reference_divider_d,
                          bus_clock_divider_d);
  end
  assign fixed_frequency_valid_o = ffe_q;

  // internal reference: one pulse per period; halted in stop to save power
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irc_cnt_q  <= '0;
      irc_tick_q <= 1'b0;
    end else if (eff_mode == CLOCK_STOP) begin
      irc_cnt_q  <= '0;
      irc_tick_q <= 1'b0;
    end else if (irc_cnt_q == IRC_W'(IRC_CYCLES - 1)) begin
      irc_cnt_q  <= '0;
      irc_tick_q <= 1'b1;
    end else begin
      irc_cnt_q  <= irc_cnt_q + IRC_W'(1);
      irc_tick_q <= 1'b0;
    end
  end

  // external reference gate: in stop only the two enables keep it alive
  always_comb begin
    if (eff_mode == CLOCK_STOP)
      ext_run = ext_ref_stop_enable_q && ext_ref_clock_enable_q;
    else
      ext_run = ext_ref_clock_enable_q || ckg_uses_ext(eff_mode);
  end
  assign ext_tick          = ext_ref_tick_i && ext_run;
  assign ext_ref_running_o = ext_run;

  // loop control; low-power bypasses and stop power the loop down
  assign fll_if.en       = ckg_loop_on(eff_mode);
  assign fll_if.ref_tick = ckg_uses_ext(eff_mode) ? ext_tick
                                                  : irc_tick_q;

  ckg_fll #(
    .CW        (FLL_CW),
    .MULT_LOG2 (MULT_LOG2)
  ) u_fll (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .f     (fll_if.fll)
  );

  // source ahead of the bus divider
  always_comb begin
    case (eff_mode)
      LOOP_ENGAGED_INTERNAL,
      LOOP_ENGAGED_EXTERNAL:           src_tick = fll_if.out_tick;
      LOOP_BYPASSED_INTERNAL,
      LOOP_BYPASSED_INTERNAL_LOWPOWER: src_tick = irc_tick_q;
      LOOP_BYPASSED_EXTERNAL,
      LOOP_BYPASSED_EXTERNAL_LOWPOWER: src_tick = ext_tick;
      default:                         src_tick = 1'b0;
    endcase
  end

  // output bus divider, 1/2/4/8
  ckg_tick_div #(
    .CW (7)
  ) u_bus_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (eff_mode != CLOCK_STOP),
    .tick_i (src_tick),
    .sel_i  ({1'b0, bus_clock_divider_q}),
    .tick_o (generator_output_clock_o)
  );

  // fixed clock: the loop reference divided by the reference divider
  ckg_tick_div #(
    .CW (7)
  ) u_ref_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .en_i   (eff_mode != CLOCK_STOP),
    .tick_i (fll_if.ref_tick),
    .sel_i  (reference_divider_q),
    .tick_o (fixed_frequency_clock_o)
  );

  // debug clock follows the loop while the loop is powered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      dbg_clk_q <= 1'b0;
    else
      dbg_clk_q <= fll_if.out_tick && ckg_loop_on(eff_mode);
  end
  assign background_debug_clock_o = dbg_clk_q;

  // status word
  always_comb begin
    stat                   = 8'h00;
    stat[2:0]              = eff_mode;
    stat[`CKG_STAT_LOCK]   = fll_if.locked;
    stat[`CKG_STAT_FFE]    = ffe_q;
    stat[`CKG_STAT_EXTRUN] = ext_run;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (re_i) begin
      case (addr_i)
        `CKG_CTRL_OFS: rdata_o <= {3'h0, ext_ref_stop_enable_q,
                                   ext_ref_clock_enable_q, mode_q};
        `CKG_DIV_OFS:  rdata_o <= {3'h0, bus_clock_divider_q,
                                   reference_divider_q};
        `CKG_STAT_OFS: rdata_o <= stat;
        default:       rdata_o <= 8'h00;
      endcase
    end else
      rdata_o <= 8'h00;
  end

  a_mode_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    ckg_run_mode(mode_q))
    else $error("mode register holds a non-run code");

  a_reset_mode: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (mode_q == LOOP_ENGAGED_INTERNAL && !fll_if.ref_tick))
    else $error("reset did not select engaged internal");

  a_ext_src: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_mode == LOOP_ENGAGED_EXTERNAL) |->
      (src_tick == fll_if.out_tick && fll_if.ref_tick == ext_tick))
    else $error("engaged external not fed by loop on external ref");

  a_byp_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_mode == LOOP_BYPASSED_INTERNAL) |->
      (fll_if.en && src_tick == irc_tick_q && fll_if.ref_tick == irc_tick_q))
    else $error("bypassed internal routing wrong");

  a_debug_clock: assert property (@(posedge clk_i) disable iff (rst_i)
    (fll_if.out_tick && (eff_mode == LOOP_ENGAGED_INTERNAL ||
     eff_mode == LOOP_ENGAGED_EXTERNAL ||
     eff_mode == LOOP_BYPASSED_INTERNAL)) |=> background_debug_clock_o)
    else $error("debug clock missed a loop pulse");

  a_stop_ext: assert property (@(posedge clk_i) disable iff (rst_i)
    (stop_i && ext_ref_stop_enable_q && ext_ref_clock_enable_q) |->
      (ext_ref_running_o && (ext_tick == ext_ref_tick_i)))
    else $error("external reference halted in stop");

  a_ffclk_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (fll_if.ref_tick && reference_divider_q == 3'h0 && !stop_i)
      |=> fixed_frequency_clock_o)
    else $error("fixed clock missed a reference tick");

  a_eng_valid: assert property (@(posedge clk_i) disable iff (rst_i)
    ckg_engaged(mode_q) |-> fixed_frequency_valid_o)
    else $error("valid low in an engaged mode");

  a_byp_bad: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ckg_engaged(mode_q) && reference_divider_q <
     3'(bus_clock_divider_q) + 3'h2) |-> !fixed_frequency_valid_o)
    else $error("valid high for a failing divider pair");

  a_ffe_track: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(reference_divider_q) |->
      (fixed_frequency_valid_o == ckg_ffe_ok(mode_q, reference_divider_q,
                                             bus_clock_divider_q)))
    else $error("valid flag lags a divider change");

  a_byp_good: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ckg_engaged(mode_q) && reference_divider_q >=
     3'(bus_clock_divider_q) + 3'h2) |-> fixed_frequency_valid_o)
    else $error("valid low for a passing divider pair");

  // a_ffe_mode below checks registered state; the flag and the fields move on one edge,
  // so a one-cycle lag anywhere in the decode trips it at once
  a_stop_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_i |=> (!generator_output_clock_o && !fixed_frequency_clock_o))
    else $error("clock pulse left while stopped");

  a_int_src: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_mode == LOOP_ENGAGED_INTERNAL) |->
      (src_tick == fll_if.out_tick && fll_if.ref_tick == irc_tick_q))
    else $error("engaged internal not fed by loop on internal ref");

  a_lp_dbg_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_mode == LOOP_BYPASSED_INTERNAL_LOWPOWER ||
     eff_mode == LOOP_BYPASSED_EXTERNAL_LOWPOWER)
      |=> !background_debug_clock_o)
    else $error("debug clock ran in a low-power bypass");

  a_ffe_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    ($changed(mode_q) || $changed(bus_clock_divider_q)) |->
      (fixed_frequency_valid_o == ckg_ffe_ok(mode_q, reference_divider_q,
                                             bus_clock_divider_q)))
    else $error("valid flag lags a mode or bus divider change");

endmodule : ckg_top

// File: verilog/ckg_map.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by bare name; 8-bit register port, 4-bit address
`ifndef CKG_MAP_SVH
`define CKG_MAP_SVH

// register offsets on the plain register port
`define CKG_CTRL_OFS 4'h0
`define CKG_DIV_OFS 4'h1
`define CKG_STAT_OFS 4'h2

// control register fields
`define CKG_CTRL_MODE_LSB 0
`define CKG_CTRL_EXT_CLK_EN 3
`define CKG_CTRL_EXT_STOP_EN 4

// divider register fields
`define CKG_DIV_REF_LSB 0
`define CKG_DIV_BUS_LSB 3

// status register fields (mode field sits at bits 2:0)
`define CKG_STAT_LOCK 3
`define CKG_STAT_FFE 4
`define CKG_STAT_EXTRUN 5

// reset values
`define CKG_RST_MODE 3'h0
`define CKG_RST_REF_DIV 3'h0
`define CKG_RST_BUS_DIV 2'h1

// timing: system clock rate and internal reference period
`define CKG_CLK_MHZ 200
`define CKG_IRC_PERIOD_NS 32000
`define CKG_IRC_CYCLES ((`CKG_IRC_PERIOD_NS * `CKG_CLK_MHZ) / 1000)

// output must be at least four times the fixed clock: bus div + 2 <= ref div
`define CKG_FFE_MARGIN 2

`endif

// File: verilog/ckg_pkg.sv
// types and shared decode functions of the clock generator
// assumes: ckg_map.svh is on the include path
`include "ckg_map.svh"

package ckg_pkg;

  // operating modes, gray coded along the usual path
  typedef enum logic [2:0] {
    LOOP_ENGAGED_INTERNAL           = 3'h0,
    LOOP_ENGAGED_EXTERNAL           = 3'h1,
    LOOP_BYPASSED_INTERNAL          = 3'h3,
    LOOP_BYPASSED_INTERNAL_LOWPOWER = 3'h2,
    LOOP_BYPASSED_EXTERNAL          = 3'h6,
    LOOP_BYPASSED_EXTERNAL_LOWPOWER = 3'h7,
    CLOCK_STOP                      = 3'h4
  } ckg_mode_t;

  // low bits set for a divide by two to the power e
  function automatic logic [7:0] ckg_mask(input logic [2:0] e);
    ckg_mask = 8'((9'h001 << e) - 9'h001);
  endfunction : ckg_mask

  // the six modes software may select
  function automatic logic ckg_run_mode(input logic [2:0] m);
    ckg_run_mode = (m != 3'(CLOCK_STOP)) && (m != 3'h5);
  endfunction : ckg_run_mode

  function automatic logic ckg_engaged(input ckg_mode_t m);
    ckg_engaged = (m == LOOP_ENGAGED_INTERNAL) ||
                  (m == LOOP_ENGAGED_EXTERNAL);
  endfunction : ckg_engaged

  // loop powered: both engaged modes and the two full-power bypasses
  function automatic logic ckg_loop_on(input ckg_mode_t m);
    ckg_loop_on = ckg_engaged(m) || (m == LOOP_BYPASSED_INTERNAL) ||
                  (m == LOOP_BYPASSED_EXTERNAL);
  endfunction : ckg_loop_on

  function automatic logic ckg_uses_ext(input ckg_mode_t m);
    ckg_uses_ext = (m == LOOP_ENGAGED_EXTERNAL) ||
                   (m == LOOP_BYPASSED_EXTERNAL) ||
                   (m == LOOP_BYPASSED_EXTERNAL_LOWPOWER);
  endfunction : ckg_uses_ext

  // fixed clock valid: always when engaged, divider check when bypassed
  function automatic logic ckg_ffe_ok(input ckg_mode_t m,
                                      input logic [2:0] ref_div,
                                      input logic [1:0] bus_div);
    if (ckg_engaged(m))
      ckg_ffe_ok = 1'b1;
    else if (m == CLOCK_STOP)
      ckg_ffe_ok = 1'b0;
    else
      ckg_ffe_ok = ref_div >= (3'(bus_div) + 3'(`CKG_FFE_MARGIN));
  endfunction : ckg_ffe_ok

endpackage : ckg_pkg

// File: verilog/ckg_fll_if.sv
// signals between the mode control and the frequency-locked loop
// assumes: both ends run on the one system clock
interface ckg_fll_if;
  logic en;        // loop powered
  logic ref_tick;  // one pulse per reference period
  logic out_tick;  // loop output pulse
  logic locked;    // one full reference period measured

  modport ctl (output en, ref_tick, input out_tick, locked);
  modport fll (input en, ref_tick, output out_tick, locked);
endinterface : ckg_fll_if

// File: verilog/ckg_tick_div.sv
// divides a train of tick pulses by two to the power sel_i
// assumes: tick_i is a one-cycle pulse on clk_i
module ckg_tick_div
  import ckg_pkg::*;
#(
  parameter int CW = 7
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] mask;

  assign mask = CW'(ckg_mask(sel_i));

  // tick counter, cleared while disabled so the phase restarts clean
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      cnt_q <= '0;
    else if (!en_i)
      cnt_q <= '0;
    else if (tick_i)
      cnt_q <= cnt_q + CW'(1);
  end

  // pass every 2**sel-th tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      tick_o <= 1'b0;
    else
      tick_o <= en_i && tick_i && ((cnt_q & mask) == mask);
  end

  a_div_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_i && tick_i && sel_i == 3'h0) |=> tick_o)
    else $error("divide by one dropped a tick");

  a_div_no_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !(en_i && tick_i) |=> !tick_o)
    else $error("divider ticked without an input tick");

endmodule : ckg_tick_div

// File: verilog/ckg_fll.sv
// digital frequency-locked loop: measures the reference period and
// emits 2**MULT_LOG2 output pulses per reference period
// assumes: reference ticks are one-cycle pulses far apart
module ckg_fll
  import ckg_pkg::*;
#(
  parameter int CW        = 16,
  parameter int MULT_LOG2 = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ckg_fll_if.fll   f
);

  logic [CW-1:0] per_cnt_q;
  logic [CW-1:0] per_q;
  logic [CW-1:0] step;
  logic [CW-1:0] ocnt_q;
  logic          seen_q;
  logic          lock_q;
  logic          out_q;

  // output period; never below one cycle
  assign step = ((per_q >> MULT_LOG2) == '0) ? CW'(1) : (per_q >> MULT_LOG2);
  assign f.out_tick = out_q;
  assign f.locked   = lock_q;

  // period counter saturates so a lost reference cannot wrap
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      per_cnt_q <= '0;
    else if (!f.en || f.ref_tick)
      per_cnt_q <= '0;
    else if (per_cnt_q != '1)
      per_cnt_q <= per_cnt_q + CW'(1);
  end

  // lock after one full measured period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_q  <= '0;
      seen_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (!f.en) begin
      per_q  <= '0;
      seen_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (f.ref_tick) begin
      per_q  <= per_cnt_q + CW'(1);
      seen_q <= 1'b1;
      lock_q <= seen_q;
    end
  end

  // output oscillator, silent until locked
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ocnt_q <= '0;
      out_q  <= 1'b0;
    end else if (!f.en || !lock_q) begin
      ocnt_q <= '0;
      out_q  <= 1'b0;
    end else if (ocnt_q >= step - CW'(1)) begin
      ocnt_q <= '0;
      out_q  <= 1'b1;
    end else begin
      ocnt_q <= ocnt_q + CW'(1);
      out_q  <= 1'b0;
    end
  end

  a_fll_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !f.en |=> (!f.out_tick && !f.locked))
    else $error("loop active while disabled");

endmodule : ckg_fll

// File: testbench/ckg_ext_ref.sv
// partner model: external reference oscillator, one tick per period
// assumes: shares the generator clock; period_i only changes while idle
module ckg_ext_ref (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [7:0] period_i,
  output logic            tick_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_q;
  logic       wrap;
  assign wrap = (cnt_q == period_i - 8'h01);
  // a stopped oscillator gives no ticks, so the phase restarts from zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= wrap;
      cnt_q  <= wrap ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule : ckg_ext_ref

// File: testbench/test_internal_clock_source_modes.sv
// self-checking bench of the clock generator: registers, flag, clocks
// assumes: internal reference shortened to 16 cycles, loop multiplies by 4
`define TB_CHK(nm, e, g) check(nm, 16'(e), 16'(g))
module test_internal_clock_source_modes;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0;
  logic        stop_i = 1'b0, ext_run = 1'b1, ext_tick;
  logic [3:0]  addr_i = 4'h0;
  logic [7:0]  wdata_i = 8'h00, rdata_o, rd_val;
  logic        gen_clk, dbg_clk, ff_clk, ff_valid, ext_running;
  logic [15:0] n_gen, n_dbg, n_ff;
  logic [2:0]  m, r, cur_mode;
  logic [1:0]  b;
  integer      fail_count = 0, samples_checked = 0, seed = 53349, i;
  // clocks per 512-cycle window for each mode case (ext period 32)
  logic [7:0]  tc_ctrl [7] = '{8'h00, 8'h00, 8'h01, 8'h03,
                               8'h02, 8'h06, 8'h07};
  logic [7:0]  tc_div  [7] = '{8'h00, 8'h11, 8'h08, 8'h00,
                               8'h18, 8'h00, 8'h08};
  logic [15:0] tc_gen  [7] = '{16'h0080, 16'h0020, 16'h0020, 16'h0020,
                               16'h0004, 16'h0010, 16'h0008};
  logic [15:0] tc_dbg  [7] = '{16'h0080, 16'h0080, 16'h0040, 16'h0080,
                               16'h0000, 16'h0040, 16'h0000};
  logic [15:0] tc_ff   [7] = '{16'h0020, 16'h0010, 16'h0010, 16'h0020,
                               16'h0020, 16'h0010, 16'h0010};

  always #2.5 clk_i = ~clk_i;

  ckg_ext_ref u_ref (.clk_i(clk_i), .rst_i(rst_i), .run_i(ext_run),
                     .period_i(8'h20), .tick_o(ext_tick));
  ckg_top #(.IRC_CYCLES(16)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .ext_ref_tick_i(ext_tick), .stop_i(stop_i),
    .generator_output_clock_o(gen_clk),
    .background_debug_clock_o(dbg_clk),
    .fixed_frequency_clock_o(ff_clk),
    .fixed_frequency_valid_o(ff_valid),
    .ext_ref_running_o(ext_running));

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i    <= 1'b0;
    #1;
  endtask : wr

  // data stands only in the cycle after the strobe, zero after that
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1;
    rd_val = rdata_o;
    @(posedge clk_i);
    #1;
    `TB_CHK("rdata idle", 8'h00, rdata_o);
  endtask : rd

  // counts pulses over a window; each pulse stands exactly one cycle
  task automatic meas(input int n);
    n_gen = 16'h0000;
    n_dbg = 16'h0000;
    n_ff  = 16'h0000;
    repeat (n) begin
      @(posedge clk_i);
      #1;
      n_gen += 16'(gen_clk);
      n_dbg += 16'(dbg_clk);
      n_ff  += 16'(ff_clk);
    end
  endtask : meas

  function automatic logic exp_ffe(input logic [2:0] md,
                                   input logic [2:0] rv,
                                   input logic [1:0] bv);
    if (md == 3'h0 || md == 3'h1)
      exp_ffe = 1'b1;
    else
      exp_ffe = ({1'b0, rv} >= {2'b00, bv} + 4'h2);
  endfunction : exp_ffe

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `TB_CHK("valid after reset", 1'b1, ff_valid);
    rd(4'h0);
    `TB_CHK("ctrl reset", 8'h00, rd_val);
    rd(4'h1);
    `TB_CHK("div reset", 8'h08, rd_val);
    wr(4'h2, 8'hFF);
    rd(4'h2);
    `TB_CHK("stat reset", 8'h10, rd_val & 8'hF7);
    rd(4'hF);
    `TB_CHK("unmapped read", 8'h00, rd_val);
    cur_mode = 3'h0;
  endtask : do_reset

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // watchdog: the whole sequence needs roughly 7500 cycles
  initial begin
    #(60000 * 5);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    do_reset();
    // every mode code first, then random ones; the stop and unused codes are refused
    for (i = 0; i < 96; i++) begin
      m = (i < 8) ? 3'(i) : 3'($random(seed));
      r = 3'($random(seed));
      b = 2'($random(seed));
      wr(4'h1, {3'b000, b, r});
      `TB_CHK("valid on div", exp_ffe(cur_mode, r, b), ff_valid);
      wr(4'h0, {5'b00000, m});
      if (m != 3'h4 && m != 3'h5)
        cur_mode = m;
      `TB_CHK("valid on mode", exp_ffe(cur_mode, r, b), ff_valid);
      rd(4'h2);
      `TB_CHK("stat mode", cur_mode, rd_val[2:0]);
      `TB_CHK("stat valid", exp_ffe(cur_mode, r, b), rd_val[4]);
    end
    // every divider pair in a bypass mode, the boundary cases included
    wr(4'h0, 8'h06);
    for (i = 0; i < 32; i++) begin
      r = 3'(i);
      b = 2'(i >> 3);
      wr(4'h1, {3'b000, b, r});
      `TB_CHK("bypass valid", exp_ffe(3'h6, r, b), ff_valid);
    end
    // output, debug and fixed clock rates in each running mode
    for (i = 0; i < 7; i++) begin
      wr(4'h1, tc_div[i]);
      wr(4'h0, tc_ctrl[i]);
      meas(256);
      meas(512);
      `TB_CHK("output clock", tc_gen[i], n_gen);
      `TB_CHK("debug clock", tc_dbg[i], n_dbg);
      `TB_CHK("fixed clock", tc_ff[i], n_ff);
    end
    // external low-power bypass with the oscillator halted: no pulses;
    // the first few cycles are skipped, a tick may still be in flight
    @(posedge clk_i);
    ext_run <= 1'b0;
    meas(8);
    meas(256);
    `TB_CHK("output no ext", 16'h0000, n_gen);
    `TB_CHK("fixed no ext", 16'h0000, n_ff);
    @(posedge clk_i);
    ext_run <= 1'b1;
    // stop: only both enables keep the external reference alive
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h18);
    @(posedge clk_i);
    stop_i <= 1'b1;
    meas(256);
    `TB_CHK("ext in stop", 1'b1, ext_running);
    `TB_CHK("output in stop", 16'h0000, n_gen);
    `TB_CHK("fixed in stop", 16'h0000, n_ff);
    rd(4'h2);
    `TB_CHK("stop mode", 3'h4, rd_val[2:0]);
    `TB_CHK("stat ext run", 1'b1, rd_val[5]);
    wr(4'h0, 8'h08);
    `TB_CHK("ext stop no sten", 1'b0, ext_running);
    wr(4'h0, 8'h10);
    `TB_CHK("ext stop no clken", 1'b0, ext_running);
    @(posedge clk_i);
    stop_i <= 1'b0;
    // second reset in mid-run returns the default mode and dividers
    wr(4'h0, 8'h07);
    do_reset();
    meas(256);
    meas(512);
    `TB_CHK("output after reset", 16'h0040, n_gen);
    end_of_test();
  end
endmodule : test_internal_clock_source_modes
